// ### src/lps_pkg.sv
// Shared constants, operation codes and counter helpers for the LIFO stack.
// Assumes a single 10 MHz clock domain and a synchronous host on the same clock.
package lps_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int WORD_W      = 4;
  localparam int STACK_WORDS = 254;
  localparam int ADDR_W      = 8;
  localparam int CNT_W       = 8;
  localparam int FIFO_DEPTH  = 4;
  localparam int REQ_W       = WORD_W + 2;

  // ----------------------------------------------------------------------
  // Reset values and flag thresholds
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SEED   = 8'h01;
  localparam logic [CNT_W-1:0]  CNT_EMPTY   = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_ONE     = 8'h01;
  localparam logic [CNT_W-1:0]  CNT_NR_FULL = 8'hfd;
  localparam logic [CNT_W-1:0]  CNT_FULL    = 8'hfe;
  localparam logic [WORD_W-1:0] WORD_CLEAR  = 4'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ  = 10000;
  localparam int CLK_PERIOD_NS = 1000000 / CLK_FREQ_KHZ;
  // Upper clock limit the host must respect; the logic itself does not check it
  localparam int MAX_CLK_KHZ   = 15000;

  // ----------------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_IDLE = 4'b0001,
    OP_PUSH = 4'b0010,
    OP_POP  = 4'b0100,
    OP_BOTH = 4'b1000
  } lps_op_e;

  function automatic lps_op_e lps_decode(input logic push, input logic pop);
    lps_op_e op;
    op = OP_IDLE;
    if (push && pop) begin
      op = OP_BOTH;
    end else if (push) begin
      op = OP_PUSH;
    end else if (pop) begin
      op = OP_POP;
    end
    return op;
  endfunction : lps_decode

  // ----------------------------------------------------------------------
  // Shift-register address counter
  // ----------------------------------------------------------------------
  // Maximal feedback from taps 8,6,5,4; the all-zero state is never entered
  function automatic logic [ADDR_W-1:0] lps_step_up(input logic [ADDR_W-1:0] s);
    logic fb;
    fb = s[7] ^ s[5] ^ s[4] ^ s[3];
    return {s[6:0], fb};
  endfunction : lps_step_up

  // Exact inverse of the up step, so push then pop returns to the same address
  function automatic logic [ADDR_W-1:0] lps_step_dn(input logic [ADDR_W-1:0] s);
    logic msb;
    msb = s[0] ^ s[6] ^ s[5] ^ s[4];
    return {msb, s[7:1]};
  endfunction : lps_step_dn

endpackage : lps_pkg

// ### src/lps_fifo.sv
// Small synchronous request FIFO with valid/ready on both sides.
// Assumes both sides run on mclk; ce low freezes every bit of state.
`timescale 1ns/1ns
module lps_fifo #(
  parameter int WIDTH = lps_pkg::REQ_W,
  parameter int DEPTH = lps_pkg::FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_MAX  = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
    logic                        full;
  } lps_fifo_s;

  lps_fifo_s st_reg;
  lps_fifo_s st_next;
  logic      do_wr;
  logic      do_rd;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    do_wr   = in_valid && !st_reg.full;
    do_rd   = out_ready && (st_reg.count != '0);
    if (do_wr) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = (st_reg.wr_ptr == PTR_LAST) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      st_next.rd_ptr = (st_reg.rd_ptr == PTR_LAST) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (do_rd && !do_wr) begin
      st_next.count = st_reg.count - 1'b1;
    end
    st_next.full = (st_next.count == CNT_MAX);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign in_ready  = !st_reg.full;
  assign out_valid = (st_reg.count != '0);
  assign out_data  = st_reg.mem[st_reg.rd_ptr];

endmodule : lps_fifo

// ### src/lps_stack.sv
// Last-in/first-out push-down stack of 4-bit words with status flags.
// Assumes a host on mclk issuing push/pop requests; requests queue in a
// four-entry FIFO and are executed one per enabled cycle unless held.
// The host must stop on req_ready low; a request sent into a full queue is lost.
`timescale 1ns/1ns

// Function
// - Hold 254 four-bit words, parallel in/out.
// - Output shows youngest word not yet popped.
// - Drive full, almost-full, empty, almost-empty flags.
// - Almost flags warn one operation in advance.
// - All sampling and updates on rising clock.
// - Four operations; idle changes nothing.
// - Push loads output, shifts holding, increments, writes.
// - Pop loads readback, keeps holding, decrements.
// - Readback from holding after push, else memory.
// - Push with pop loads output only.
// - Address counter is up/down shift register.
module lps_stack #(
  parameter int WORD_W = lps_pkg::WORD_W,
  parameter int FIFO_D = lps_pkg::FIFO_DEPTH
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic [WORD_W-1:0] push_word_in,
  input  wire logic              push_req,
  input  wire logic              pop_req,
  output logic                   req_ready,
  input  wire logic              stack_hold,
  output logic      [WORD_W-1:0] top_word_out,
  output logic                   full,
  output logic                   almost_full,
  output logic                   empty,
  output logic                   almost_empty
);

  localparam int ADDR_W = lps_pkg::ADDR_W;
  localparam int CNT_W  = lps_pkg::CNT_W;
  localparam int REQ_W  = WORD_W + 2;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] top;
    logic [WORD_W-1:0] hold;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0]  depth;
    logic              last_push;
    logic              full;
    logic              nr_full;
    logic              empty;
    logic              nr_empty;
    logic              ready;
  } lps_stack_s;

  lps_stack_s        st_reg;
  lps_stack_s        st_next;
  logic [WORD_W-1:0] mem_arr [0:(1<<ADDR_W)-1];

  logic [REQ_W-1:0]  req_in;
  logic [REQ_W-1:0]  req_out;
  logic              req_valid;
  logic              req_take;
  logic              fifo_ready;

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] wr_data;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] readback;
  lps_pkg::lps_op_e  op;

  // ----------------------------------------------------------------------
  // Request queue
  // ----------------------------------------------------------------------
  // Each entry carries the two request bits and the word, so a push and a
  // pop asked together stay together through the queue
  assign req_in   = {push_req, pop_req, push_word_in};
  // Holding the stack stalls the drain, which backs up into req_ready
  assign req_take = !stack_hold;

  lps_fifo #(
    .WIDTH (REQ_W),
    .DEPTH (FIFO_D)
  ) u_req_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .in_data   (req_in),
    .in_valid  (push_req || pop_req),
    .in_ready  (fifo_ready),
    .out_data  (req_out),
    .out_valid (req_valid),
    .out_ready (req_take)
  );

  // ----------------------------------------------------------------------
  // Readback path
  // ----------------------------------------------------------------------
  assign rd_word  = mem_arr[st_reg.addr];
  // After a push the memory copy is also valid, but the holding register
  // is the documented source and avoids a read-after-write dependency
  assign readback = st_reg.last_push ? st_reg.hold : rd_word;

  // ----------------------------------------------------------------------
  // Operation decode and next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    wr_en   = 1'b0;
    wr_addr = st_reg.addr;
    wr_data = st_reg.top;
    op      = lps_pkg::OP_IDLE;

    if (req_valid && req_take) begin
      op = lps_pkg::lps_decode(req_out[REQ_W-1], req_out[REQ_W-2]);
      // Misuse by the host is dropped rather than corrupting the counter
      if ((op == lps_pkg::OP_PUSH) && st_reg.full) begin
        op = lps_pkg::OP_IDLE;
      end
      if ((op == lps_pkg::OP_POP) && st_reg.empty) begin
        op = lps_pkg::OP_IDLE;
      end
    end

    // Shift-register counting never enters all-zero, so 255 codes hold the
    // seed plus 254 words; pop steps back along the same sequence
    unique case (op)
      lps_pkg::OP_PUSH: begin
        // Old top moves to holding and is written at the new address in
        // the same edge, standing in for the clock-low write phase
        st_next.top       = req_out[WORD_W-1:0];
        st_next.hold      = st_reg.top;
        st_next.addr      = lps_pkg::lps_step_up(st_reg.addr);
        st_next.depth     = st_reg.depth + 1'b1;
        st_next.last_push = 1'b1;
        wr_en             = 1'b1;
        wr_addr           = st_next.addr;
        wr_data           = st_reg.top;
      end
      lps_pkg::OP_POP: begin
        // Holding register is left as it was on a pop
        st_next.top       = readback;
        st_next.hold      = st_reg.hold;
        st_next.addr      = lps_pkg::lps_step_dn(st_reg.addr);
        st_next.depth     = st_reg.depth - 1'b1;
        st_next.last_push = 1'b0;
      end
      lps_pkg::OP_BOTH: begin
        // Holding register and counter stay put
        st_next.top       = req_out[WORD_W-1:0];
        st_next.last_push = 1'b0;
      end
      lps_pkg::OP_IDLE: begin
        // Nothing moves, so the readback source stays as it was
        st_next = st_reg;
      end
    endcase

    // Flags follow the new depth so they are registered with the data
    st_next.full     = (st_next.depth == lps_pkg::CNT_FULL);
    st_next.empty    = (st_next.depth == lps_pkg::CNT_EMPTY);
    st_next.nr_full  = (st_next.depth == lps_pkg::CNT_NR_FULL);
    st_next.nr_empty = (st_next.depth == lps_pkg::CNT_ONE) ||
                       (st_next.depth == lps_pkg::CNT_EMPTY);

    // Queue space is registered so req_ready leaves a flip-flop directly;
    // the price is one cycle of lag, covered by the queue refusing overflow
    st_next.ready    = fifo_ready;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg.top       <= lps_pkg::WORD_CLEAR;
      st_reg.hold      <= lps_pkg::WORD_CLEAR;
      st_reg.addr      <= lps_pkg::ADDR_SEED;
      st_reg.depth     <= lps_pkg::CNT_EMPTY;
      st_reg.last_push <= 1'b0;
      st_reg.full      <= 1'b0;
      st_reg.nr_full   <= 1'b0;
      st_reg.empty     <= 1'b1;
      st_reg.nr_empty  <= 1'b1;
      st_reg.ready     <= 1'b1;
    end else if (ce) begin
      st_reg        <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Word storage
  // ----------------------------------------------------------------------
  // Writing at the push edge replaces the clock-low write phase; the new
  // address and the old top are both settled then, so nothing is lost
  // Word storage is not reset; locations are always written before read
  always_ff @(posedge mclk) begin
    if (ce && !srst && wr_en) begin
      mem_arr[wr_addr] <= wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // req_ready lags the FIFO by one edge; one extra queue slot would be
  // needed for zero lag, the FIFO refuses any excess write safely
  assign req_ready    = st_reg.ready;
  assign top_word_out = st_reg.top;
  assign full         = st_reg.full;
  assign almost_full  = st_reg.nr_full;
  assign empty        = st_reg.empty;
  assign almost_empty = st_reg.nr_empty;

endmodule : lps_stack

// ### test/lps_stack_props.sv
// Concurrent checks on the ports of the LIFO stack.
// Assumes one clock domain, mclk, with srst synchronous and active high.
`timescale 1ns/1ns
module lps_stack_props #(
  parameter int WORD_W = 4,
  parameter int FIFO_D = 4
) (
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              ce,
  input wire logic [WORD_W-1:0] push_word_in,
  input wire logic              push_req,
  input wire logic              pop_req,
  input wire logic              req_ready,
  input wire logic              stack_hold,
  input wire logic [WORD_W-1:0] top_word_out,
  input wire logic              full,
  input wire logic              almost_full,
  input wire logic              empty,
  input wire logic              almost_empty
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Eight quiet cycles drain a full queue plus the execute stage
  sequence quiet_s;
    (!push_req && !pop_req && !stack_hold && ce)[*8];
  endsequence
  reset_vals_a: assert property ($fell(srst) |-> top_word_out == '0 && empty && almost_empty
    && !full && !almost_full && req_ready) else $error("reset values wrong");
  empty_flags_a: assert property (empty |-> almost_empty && !full && !almost_full)
    else $error("empty with inconsistent flags");
  full_flags_a: assert property (full |-> !almost_full && !almost_empty && !empty)
    else $error("full with inconsistent flags");
  freeze_ce_a: assert property (!ce |=> $stable(top_word_out) && $stable(full)
    && $stable(empty)) else $error("state moved with ce low");
  idle_stable_a: assert property (quiet_s |=> $stable(top_word_out) && $stable(empty)
    && $stable(full)) else $error("idle changed the stack");
  first_push_a: assert property (empty ##1 !empty |-> almost_empty)
    else $error("first word left almost_empty low");
  af_before_full_a: assert property (!full ##1 full |-> $past(almost_full))
    else $error("full without prior almost_full");
  ae_before_empty_a: assert property (!srst && !empty ##1 empty |-> $past(almost_empty))
    else $error("empty without prior almost_empty");
  full_leaves_a: assert property (!srst && full ##1 !full |-> almost_full)
    else $error("leaving full skipped almost_full");
  ready_drained_a: assert property (quiet_s |-> req_ready)
    else $error("queue not ready after draining");
  cover property (full);
  cover property ($fell(req_ready));
  cover property (push_req && pop_req);
endmodule : lps_stack_props

// ### test/lps_host.sv
// Host controller model issuing one push/pop request per call.
// Assumes mclk from the bench; obeys req_ready and the stack flags.
`timescale 1ns/1ns
module lps_host (
  input  wire logic                        mclk,
  input  wire logic                        req_ready,
  input  wire logic                        full,
  input  wire logic                        empty,
  output logic      [lps_pkg::WORD_W-1:0] push_word_in,
  output logic                             push_req,
  output logic                             pop_req
);
  initial begin
    push_word_in = '0;
    push_req = 1'b0;
    pop_req = 1'b0;
  end
  // force_it ignores req_ready, only to provoke a refused request
  task automatic send(input logic p, input logic q, input logic [lps_pkg::WORD_W-1:0] w,
                      input logic force_it);
    int n;
    n = 0;
    @(posedge mclk);
    while (!req_ready && !force_it && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (!(p && !q && full) && !(q && !p && empty)) begin
      push_req <= p;
      pop_req <= q;
      push_word_in <= w;
      @(posedge mclk);
    end
    push_req <= 1'b0;
    pop_req <= 1'b0;
    // Released data lines must not keep the last word
    push_word_in <= ~w;
  endtask : send
endmodule : lps_host

// ### test/test_lps_stack.sv
// Self-checking bench for the LIFO stack, driven through the host model.
// Assumes the stack and its request queue share one 10 MHz clock.
`timescale 1ns/1ns
module test_lps_stack;
  logic                       mclk, srst, ce, stack_hold, push_req, pop_req, req_ready;
  logic                       full, almost_full, empty, almost_empty;
  logic [lps_pkg::WORD_W-1:0] push_word_in, top_word_out;
  int                         bad_count, n_compared;
  // ----------------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------------
  lps_stack #(.WORD_W(lps_pkg::WORD_W), .FIFO_D(lps_pkg::FIFO_DEPTH)) u_dut (
    .mclk(mclk), .srst(srst), .ce(ce), .push_word_in(push_word_in), .push_req(push_req),
    .pop_req(pop_req), .req_ready(req_ready), .stack_hold(stack_hold),
    .top_word_out(top_word_out), .full(full), .almost_full(almost_full), .empty(empty),
    .almost_empty(almost_empty));
  lps_host u_host (.mclk(mclk), .req_ready(req_ready), .full(full), .empty(empty),
    .push_word_in(push_word_in), .push_req(push_req), .pop_req(pop_req));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] flags();
    return {4'h0, full, almost_full, empty, almost_empty};
  endfunction : flags
  task automatic op(input logic p, input logic q, input logic [3:0] w);
    u_host.send(p, q, w, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
  endtask : op
  task automatic results();
    $display("checks %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    chk("reset flags", flags(), 8'h03);
    chk("reset top", {4'h0, top_word_out}, 8'h00);
    chk("reset ready", {7'h0, req_ready}, 8'h01);
  endtask : t_reset
  task automatic t_basic();
    op(1, 0, 4'h5);
    chk("push1 top", {4'h0, top_word_out}, 8'h05);
    chk("push1 flags", flags(), 8'h01);
    op(1, 0, 4'ha);
    chk("push2 top", {4'h0, top_word_out}, 8'h0a);
    chk("push2 flags", flags(), 8'h00);
    op(1, 1, 4'hc);
    chk("both top", {4'h0, top_word_out}, 8'h0c);
    chk("both flags", flags(), 8'h00);
    op(0, 1, 4'h0);
    chk("pop mem top", {4'h0, top_word_out}, 8'h05);
    op(1, 0, 4'h9);
    op(0, 1, 4'h0);
    chk("pop hold top", {4'h0, top_word_out}, 8'h05);
    @(posedge mclk);
    ce <= 1'b0;
    op(1, 0, 4'h3);
    @(posedge mclk);
    ce <= 1'b1;
    op(0, 0, 4'h0);
    chk("ce low top", {4'h0, top_word_out}, 8'h05);
    op(0, 1, 4'h0);
    chk("pop last flags", flags(), 8'h03);
  endtask : t_basic
  task automatic t_fill();
    for (int i = 0; i < 254; i++) begin
      op(1, 0, 4'(i) ^ 4'h5);
      if (i == 252) chk("almost full", flags(), 8'h04);
    end
    chk("full", flags(), 8'h08);
    for (int i = 253; i > 0; i--) begin
      op(0, 1, 4'h0);
      chk("pop order", {4'h0, top_word_out}, {4'h0, 4'(i - 1) ^ 4'h5});
    end
    chk("one left", flags(), 8'h01);
    op(0, 1, 4'h0);
    chk("drained", flags(), 8'h03);
  endtask : t_fill
  task automatic t_buffer();
    @(posedge mclk);
    stack_hold <= 1'b1;
    for (int i = 1; i < 5; i++) u_host.send(1, 0, 4'(i), 1'b0);
    repeat (2) @(posedge mclk);
    #1;
    chk("queue full", {7'h0, req_ready}, 8'h00);
    u_host.send(1, 0, 4'h7, 1'b1);
    repeat (2) @(posedge mclk);
    #1;
    chk("held flags", flags(), 8'h03);
    stack_hold <= 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    chk("drain top", {4'h0, top_word_out}, 8'h04);
    for (int i = 3; i > 0; i--) begin
      op(0, 1, 4'h0);
      chk("drain pop", {4'h0, top_word_out}, 8'(i));
    end
  endtask : t_buffer
  task automatic t_rst_mid();
    op(1, 0, 4'h6);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("mid reset flags", flags(), 8'h03);
    chk("mid reset top", {4'h0, top_word_out}, 8'h00);
    chk("mid reset ready", {7'h0, req_ready}, 8'h01);
    op(1, 0, 4'hb);
    chk("after reset top", {4'h0, top_word_out}, 8'h0b);
    chk("after reset flags", flags(), 8'h01);
  endtask : t_rst_mid
  initial begin
    bad_count = 0;
    n_compared = 0;
    srst = 1'b1;
    ce = 1'b1;
    stack_hold = 1'b0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_basic();
    t_fill();
    t_buffer();
    t_rst_mid();
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    results();
  end
endmodule : test_lps_stack
bind lps_stack lps_stack_props #(.WORD_W(WORD_W), .FIFO_D(FIFO_D)) u_props (
  .mclk(mclk), .srst(srst), .ce(ce), .push_word_in(push_word_in), .push_req(push_req),
  .pop_req(pop_req), .req_ready(req_ready), .stack_hold(stack_hold),
  .top_word_out(top_word_out), .full(full), .almost_full(almost_full), .empty(empty),
  .almost_empty(almost_empty));
